// file: src/ddbl_pkg.sv
// ==========================================================================
// Shared constants for the double-buffered converter latch controller.
// ==========================================================================
package ddbl_pkg;

  // ========================================================================
  // Data word layout.
  // ========================================================================
  localparam int DATA_W = 16;
  localparam int TOP_BIT = 15;

  // ========================================================================
  // Clock and pin timing, in nanoseconds as given.
  // ========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_LOW_NS = 100;  // Plain default; raise for slower parts.
  localparam int DATA_HOLD_NS = 20;  // Plain default for data hold after the strobe.
  localparam int UPDATE_GAP_NS = 100;
  localparam int SETTLE_NS = 13000;

  // Width of the phase timer; must hold the longest phase count.
  localparam int TIMER_W = 16;

  // Idle pin levels keep both ranks latched and no input floating.
  localparam logic IDLE_SELECT_N = 1'b1;
  localparam logic IDLE_LOAD_N = 1'b1;
  localparam logic IDLE_UPDATE = 1'b0;

  // Least times round up, and no phase is shorter than one cycle.
  function automatic int ddbl_ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c;
  endfunction : ddbl_ns_to_cycles

  localparam int STROBE_LOW_CYC = ddbl_ns_to_cycles(STROBE_LOW_NS);
  localparam int DATA_HOLD_CYC = ddbl_ns_to_cycles(DATA_HOLD_NS);
  localparam int UPDATE_GAP_CYC = ddbl_ns_to_cycles(UPDATE_GAP_NS);
  localparam int SETTLE_CYC = ddbl_ns_to_cycles(SETTLE_NS);

  // ========================================================================
  // Transfer modes selected per request.
  // ========================================================================
  localparam logic [1:0] MODE_DOUBLE = 2'h0;
  localparam logic [1:0] MODE_LOAD = 2'h1;
  localparam logic [1:0] MODE_UPDATE = 2'h2;
  localparam logic [1:0] MODE_EDGE = 2'h3;

endpackage : ddbl_pkg

// file: src/ddbl_timer.sv
`timescale 1ns/1ns
// ==========================================================================
// Phase timer: done is high in the last cycle of a phase of len cycles.
// ==========================================================================
module ddbl_timer
  import ddbl_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [W-1:0] len,
  output logic done
);

  typedef struct packed {
    logic busy;
    logic [W-1:0] cnt;
  } ddbl_tmr_t;

  ddbl_tmr_t tmr_q;
  ddbl_tmr_t tmr_d;

  // Count down; a new start overrides, so phases chain without a gap cycle.
  always_comb begin
    tmr_d = tmr_q;
    if (tmr_q.busy) begin
      if (tmr_q.cnt == '0) begin
        tmr_d.busy = 1'b0;
      end else begin
        tmr_d.cnt = tmr_q.cnt - W'(1);
      end
    end
    if (start) begin
      tmr_d.busy = 1'b1;
      tmr_d.cnt = len - W'(1);
    end
  end

  // Synchronous reset to an idle timer.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_d;
    end
  end

  assign done = tmr_q.busy && (tmr_q.cnt == '0);

endmodule : ddbl_timer

// file: src/ddbl_host.sv
`timescale 1ns/1ns
// Functional notes
// R1: Converter loads whole 16-bit word at once.
// R2: Second rank loads only as later step.
// R3: First rank open while select and load low.
// R4: Second rank open while update is high.
// R5: Update acts apart from select.
// R6: Leave 100 ns before raising update.
// R7: Joined select/update act as master-slave register.
// R8: Rising joined edge outputs word before it.
// R9: Joined low plus high covers output settling.
// R10: Update held high makes second rank transparent.
// R11: All controls active gives full transparency.
// R12: Data lines are positive-true binary.
// R13: Unipolar coding is straight binary.
// R14: Bipolar coding is offset binary.
// R15: Invert top bit for two's complement.
// R16: Drive controls to defined levels always.
// R17: Write strobe loads, select drives select/update.
// R18: Select rising edge updates with latched word.
// R19: Capture on load strobe rise, before select.
// R20: Stretch strobe low time for slow parts.
// R21: Ranks undefined until first load and update.
// R22: All controls joined form one edge register.
// ==========================================================================
// Host-side controller that drives the converter latch pins.
// ==========================================================================
module ddbl_host
  import ddbl_pkg::*;
#(
  parameter int LOW_CYC = STROBE_LOW_CYC,
  parameter int HOLD_CYC = DATA_HOLD_CYC,
  parameter int GAP_CYC = UPDATE_GAP_CYC,
  parameter int SETTLE_CYC_P = SETTLE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic [DATA_W-1:0] req_data,
  input wire logic [1:0] req_mode,
  input wire logic req_twos_comp,
  output logic req_ready,
  output logic done,
  output logic ranks_valid,
  output logic [DATA_W-1:0] dac_data,
  output logic decoded_select_n,
  output logic first_rank_load_n,
  output logic output_update
);

  // ========================================================================
  // State.
  // ========================================================================
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_HOLD,
    ST_GAP,
    ST_UPD,
    ST_JLOW,
    ST_JHIGH
  } ddbl_state_t;

  typedef struct packed {
    ddbl_state_t state;
    logic [1:0] mode;
    logic [DATA_W-1:0] data;
    logic sel_n;
    logic load_n;
    logic upd;
    logic ready;
    logic done;
    logic loaded;
    logic valid;
  } ddbl_regs_t;

  localparam ddbl_regs_t ST_RESET = '{
    state: ST_IDLE,
    mode: MODE_DOUBLE,
    data: '0,
    sel_n: IDLE_SELECT_N,
    load_n: IDLE_LOAD_N,
    upd: IDLE_UPDATE,
    ready: 1'b1,
    done: 1'b0,
    loaded: 1'b0,
    valid: 1'b0
  };

  ddbl_regs_t st_q;
  ddbl_regs_t st_d;
  logic tmr_start;
  logic [TIMER_W-1:0] tmr_len;
  logic tmr_done;

  // Positive-true data; only the top bit is flipped for signed samples.
  function automatic logic [DATA_W-1:0] ddbl_encode(input logic [DATA_W-1:0] w,
                                                    input logic twos);
    logic [DATA_W-1:0] r;
    r = w;  // R12
    if (twos) begin
      r[TOP_BIT] = ~w[TOP_BIT];  // R15
    end
    return r;
  endfunction : ddbl_encode

  ddbl_timer #(
    .W(TIMER_W)
  ) u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(tmr_start),
    .len(tmr_len),
    .done(tmr_done)
  );

  // ========================================================================
  // Sequencer. Outside edge mode the load strobe rises before select so that capture is timed
  // from the strobe; that costs a hold phase but keeps data hold safe.
  // ========================================================================
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    tmr_start = 1'b0;
    tmr_len = '0;
    unique case (st_q.state)
      ST_IDLE: begin
        if (req_valid) begin
          st_d.ready = 1'b0;
          st_d.mode = req_mode;
          tmr_start = 1'b1;
          if (req_mode == MODE_UPDATE) begin
            // Pins stay quiet through the gap, whatever came before.
            tmr_len = TIMER_W'(GAP_CYC);  // R6
            st_d.state = ST_GAP;
          end else if (req_mode == MODE_EDGE) begin
            st_d.data = ddbl_encode(req_data, req_twos_comp);
            st_d.sel_n = 1'b0;  // R22
            st_d.load_n = 1'b0;  // R7
            tmr_len = TIMER_W'(LOW_CYC);  // R20
            st_d.state = ST_JLOW;
          end else begin
            st_d.data = ddbl_encode(req_data, req_twos_comp);  // R1
            st_d.sel_n = 1'b0;  // R3
            st_d.load_n = 1'b0;  // R17
            tmr_len = TIMER_W'(LOW_CYC);  // R20
            st_d.state = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        if (tmr_done) begin
          st_d.load_n = 1'b1;  // R19
          tmr_start = 1'b1;
          tmr_len = TIMER_W'(HOLD_CYC);
          st_d.state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tmr_done) begin
          st_d.sel_n = 1'b1;
          st_d.loaded = 1'b1;
          if (st_q.mode == MODE_LOAD) begin
            st_d.ready = 1'b1;
            st_d.done = 1'b1;
            st_d.state = ST_IDLE;
          end else begin
            tmr_start = 1'b1;
            tmr_len = TIMER_W'(GAP_CYC);  // R6
            st_d.state = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        if (tmr_done) begin
          st_d.upd = 1'b1;  // R2
          tmr_start = 1'b1;
          tmr_len = TIMER_W'(LOW_CYC);
          st_d.state = ST_UPD;
        end
      end
      ST_UPD: begin
        if (tmr_done) begin
          st_d.upd = 1'b0;  // R4
          st_d.valid = st_q.valid | st_q.loaded;  // R21
          st_d.ready = 1'b1;
          st_d.done = 1'b1;
          st_d.state = ST_IDLE;
        end
      end
      ST_JLOW: begin
        if (tmr_done) begin
          // One joined rising edge: first rank closes, second opens.
          st_d.sel_n = 1'b1;  // R8
          st_d.load_n = 1'b1;  // R22
          st_d.upd = 1'b1;  // R18
          st_d.loaded = 1'b1;
          tmr_start = 1'b1;
          tmr_len = TIMER_W'(SETTLE_CYC_P);  // R9
          st_d.state = ST_JHIGH;
        end
      end
      ST_JHIGH: begin
        if (tmr_done) begin
          st_d.upd = 1'b0;
          st_d.valid = 1'b1;  // R21
          st_d.ready = 1'b1;
          st_d.done = 1'b1;
          st_d.state = ST_IDLE;
        end
      end
    endcase
  end

  // Reset drives every control to its idle level, never floating.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= ST_RESET;  // R16
    end else begin
      st_q <= st_d;
    end
  end

  assign req_ready = st_q.ready;
  assign done = st_q.done;
  assign ranks_valid = st_q.valid;
  assign dac_data = st_q.data;
  assign decoded_select_n = st_q.sel_n;
  assign first_rank_load_n = st_q.load_n;
  assign output_update = st_q.upd;

  // ========================================================================
  // Checks. Counters measure pulse widths too long for repetition.
  // ========================================================================
  // Bound is the double-buffered transfer plus the settle phase, plus one cycle of margin.
  localparam int DONE_MAX = 2 * LOW_CYC + HOLD_CYC + GAP_CYC + SETTLE_CYC_P + 1;
  logic [15:0] lo_cnt_q;
  logic [15:0] hi_cnt_q;
  logic [15:0] busy_cnt_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lo_cnt_q <= '0;
      hi_cnt_q <= '0;
      busy_cnt_q <= '0;
    end else begin
      busy_cnt_q <= req_ready ? 16'h0000 : busy_cnt_q + 16'h0001;
      lo_cnt_q <= first_rank_load_n ? 16'h0000 : lo_cnt_q + 16'h0001;
      hi_cnt_q <= output_update ? hi_cnt_q + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_load_in_select;
    !first_rank_load_n |-> !decoded_select_n;
  endproperty
  a_load_in_select: assert property (p_load_in_select) else $error("load without select"); // R3

  property p_strobe_first;
    $rose(decoded_select_n) && !output_update |-> $past(first_rank_load_n);
  endproperty
  a_strobe_first: assert property (p_strobe_first) else $error("select rose before strobe"); // R19

  property p_gap;
    $rose(output_update) && $past(decoded_select_n) |-> $past(decoded_select_n, GAP_CYC);
  endproperty
  a_gap: assert property (p_gap) else $error("update gap too short"); // R6

  property p_update_apart;
    output_update |-> decoded_select_n && first_rank_load_n;
  endproperty
  a_update_apart: assert property (p_update_apart) else $error("update during load"); // R5

  property p_low_width;
    $rose(first_rank_load_n) |-> lo_cnt_q == 16'(LOW_CYC);
  endproperty
  a_low_width: assert property (p_low_width) else $error("strobe low width wrong"); // R20

  property p_high_width;
    $fell(output_update) |->
      hi_cnt_q == ((st_q.mode == MODE_EDGE) ? 16'(SETTLE_CYC_P) : 16'(LOW_CYC));
  endproperty
  a_high_width: assert property (p_high_width) else $error("update width wrong"); // R9

  property p_edge_word;
    $rose(output_update) && !$past(decoded_select_n) |-> $stable(dac_data);
  endproperty
  a_edge_word: assert property (p_edge_word) else $error("data moved at edge"); // R8

  property p_twos;
    req_valid && req_ready && req_mode != MODE_UPDATE |=>
      dac_data[TOP_BIT] == ($past(req_twos_comp) ^ $past(req_data[TOP_BIT]));
  endproperty
  a_twos: assert property (p_twos) else $error("top bit coding wrong"); // R15

  property p_idle_pins;
    req_ready |-> decoded_select_n && first_rank_load_n && !output_update;
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("controls not idle"); // R16

  property p_data_steady;
    !decoded_select_n && !$past(decoded_select_n) |-> $stable(dac_data);
  endproperty
  a_data_steady: assert property (p_data_steady) else $error("data moved in load"); // R1

  property p_valid;
    $rose(ranks_valid) |-> $fell(output_update);
  endproperty
  a_valid: assert property (p_valid) else $error("valid without update"); // R21

  // A counter, not a delay range: the settle phase runs past the range limit.
  property p_done_bound;
    !req_ready |-> busy_cnt_q < 16'(DONE_MAX);
  endproperty
  a_done_bound: assert property (p_done_bound) else $error("transfer never ended"); // R2

  cover property (req_valid && req_ready && req_mode == MODE_DOUBLE ##[1:200] done);
  cover property (req_valid && req_ready && req_mode == MODE_LOAD ##[1:200] done);
  cover property (req_valid && req_ready && req_mode == MODE_UPDATE ##[1:200] done);
  cover property (done && st_q.mode == MODE_EDGE && ranks_valid);

endmodule : ddbl_host

// file: tb/ddbl_dev_model.sv
`timescale 1ns/1ns
// ==========================================================================
// Behavioural converter input stage: two ranks of level latches.
// ==========================================================================
module ddbl_dev_model
  import ddbl_pkg::*;
(
  input wire logic decoded_select_n,
  input wire logic first_rank_load_n,
  input wire logic output_update,
  input wire logic [DATA_W-1:0] dac_data,
  output logic [DATA_W-1:0] rank1,
  output logic [DATA_W-1:0] rank2
);
  // Both ranks start unknown, so an update before any load shows garbage.
  // The first rank is open while select and load are both low.
  always @* begin
    if (!decoded_select_n && !first_rank_load_n) begin
      rank1 = dac_data;
    end
  end
  // The update pin alone opens the second rank; select has no say.
  always @* begin
    if (output_update) begin
      rank2 = rank1;
    end
  end
endmodule : ddbl_dev_model

// file: tb/ddbl_host_tb.sv
`timescale 1ns/1ns
// ==========================================================================
// Self-checking bench: driver notes results, a monitor compares them.
// ==========================================================================
module ddbl_host_tb;
  import ddbl_pkg::*;
  // Short phases keep the edge-mode settle wait small.
  localparam int L = 3;
  localparam int H = 1;
  localparam int G = 2;
  localparam int S = 4;
  logic clk, reset_n, req_valid, req_twos_comp, req_ready, done, ranks_valid;
  logic decoded_select_n, first_rank_load_n, output_update;
  logic [1:0] req_mode;
  logic [DATA_W-1:0] req_data, dac_data, rank1, rank2, exp_r1, exp_r2;
  logic exp_loaded, exp_rv;
  logic [DATA_W-1:0] codes [4];
  int failures, n_tests, cyc, i, j, k;
  int q_cyc[$];
  logic [DATA_W-1:0] q_val[$];
  logic q_rv[$];

  ddbl_host #(.LOW_CYC(L), .HOLD_CYC(H), .GAP_CYC(G), .SETTLE_CYC_P(S)) u_ddbl_host (
    .clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_data(req_data),
    .req_mode(req_mode), .req_twos_comp(req_twos_comp), .req_ready(req_ready),
    .done(done), .ranks_valid(ranks_valid), .dac_data(dac_data),
    .decoded_select_n(decoded_select_n), .first_rank_load_n(first_rank_load_n),
    .output_update(output_update));
  ddbl_dev_model u_ddbl_dev_model (
    .decoded_select_n(decoded_select_n), .first_rank_load_n(first_rank_load_n),
    .output_update(output_update), .dac_data(dac_data), .rank1(rank1), .rank2(rank2));

  // ========================================================================
  // Clock and shared helpers.
  // ========================================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // Holds the request up until taken, then notes the expected outcome.
  // Valid is left high so a following call can go back to back.
  task automatic send(input logic [1:0] m, input logic [DATA_W-1:0] d, input logic tc);
    int lat;
    logic [DATA_W-1:0] w;
    w = tc ? {~d[TOP_BIT], d[TOP_BIT-1:0]} : d;
    lat = (m == MODE_DOUBLE) ? L + H + G + L + 1 : (m == MODE_LOAD) ? L + H + 1 :
          (m == MODE_UPDATE) ? G + L + 1 : L + S + 1;
    req_valid <= 1'b1;
    req_mode <= m;
    req_data <= d;
    req_twos_comp <= tc;
    for (k = 0; k < 3000; k++) begin
      @(posedge clk);
      if (req_ready === 1'b1) break;
    end
    if (k == 3000) begin
      failures++;
      give_verdict();
    end
    if (m != MODE_UPDATE) begin
      exp_r1 = w;
      exp_loaded = 1'b1;
    end
    if (m != MODE_LOAD) begin
      exp_r2 = exp_r1;
      exp_rv = exp_rv | exp_loaded;
    end
    q_cyc.push_back(cyc + lat);
    q_val.push_back(exp_r2);
    q_rv.push_back(exp_rv);
  endtask : send

  // ========================================================================
  // Monitor: pin relations every cycle, oldest note at each done.
  // ========================================================================
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (reset_n === 1'b1 && output_update === 1'b1) begin
      check({first_rank_load_n, decoded_select_n}, 2'h3);
    end
    if (done === 1'b1) begin
      if (q_cyc.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        check(cyc, q_cyc.pop_front());
        check(rank2, q_val.pop_front());
        check(ranks_valid, q_rv.pop_front());
      end
    end
  end

  // ========================================================================
  // Main sequence.
  // ========================================================================
  initial begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_data = 16'h0000;
    req_mode = MODE_DOUBLE;
    req_twos_comp = 1'b0;
    failures = 0;
    n_tests = 0;
    cyc = 0;
    exp_r1 = 'x;
    exp_r2 = 'x;
    exp_loaded = 1'b0;
    exp_rv = 1'b0;
    void'($urandom(32'h4355f279));
    codes = '{16'h0000, 16'h8000, 16'hffff, 16'h0000};
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check({req_ready, done, ranks_valid, decoded_select_n, first_rank_load_n,
           output_update}, 6'h26);
    check(dac_data, 16'h0000);
    // An update with nothing loaded must not claim valid ranks.
    send(MODE_UPDATE, 16'h1234, 1'b0);
    // Every mode with boundary codes, then a random word.
    for (i = 0; i < 4; i++) begin
      codes[3] = $urandom;
      for (j = 0; j < 4; j++) begin
        send(i[1:0], codes[j], (j == 3) ? 1'($urandom) : 1'b0);
      end
    end
    send(MODE_DOUBLE, 16'h0000, 1'b1);
    // Random traffic in any order, back to back.
    for (i = 0; i < 20; i++) begin
      send(2'($urandom), 16'($urandom), 1'($urandom));
    end
    @(posedge clk);
    req_valid <= 1'b0;
    for (i = 0; i < 3000 && q_cyc.size() > 0; i++) begin
      @(posedge clk);
    end
    if (q_cyc.size() > 0) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, q_cyc.size(), 0);
    end
    give_verdict();
  end
endmodule : ddbl_host_tb
